// File: shared/apts_defines.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 16-bit register port with word offsets
`ifndef APTS_DEFINES_SVH
`define APTS_DEFINES_SVH

`define APTS_OFF_CTRL      4'h0
`define APTS_OFF_STAT      4'h1
`define APTS_OFF_BASE      4'h2
`define APTS_OFF_PSEL_LO   4'h3
`define APTS_OFF_PSEL_HI   4'h4
`define APTS_OFF_PAIRCTL0  4'h5

`define APTS_CTRL_ON       15
`define APTS_CTRL_GSW      10
`define APTS_CTRL_ORDER    6
`define APTS_CTRL_DIV_HI   2
`define APTS_CTRL_MASK     16'hb5f7
`define APTS_CTRL_RST      16'h0003

`define APTS_BASE_MASK     16'hfffe
`define APTS_PSEL_LO_MASK  16'hffff
`define APTS_PSEL_HI_MASK  16'h00ff
`define APTS_PAIR_RST      8'h00

`define APTS_TRG_OFF       5'h00
`define APTS_TRG_SW        5'h01
`define APTS_TRG_GSW       5'h02
`define APTS_TRG_SPEC      5'h03
`define APTS_TRG_PRI_LO    5'h04
`define APTS_TRG_PRI_HI    5'h0b
`define APTS_TRG_TMR1      5'h0c
`define APTS_TRG_SEC_SPEC  5'h0d
`define APTS_TRG_SEC_LO    5'h0e
`define APTS_TRG_SEC_HI    5'h16
`define APTS_TRG_CL_LO     5'h17
`define APTS_TRG_CL_HI     5'h1e
`define APTS_TRG_TMR2      5'h1f

`define APTS_CONV_TICKS    4'hc
`define APTS_ENC_SHIFT     2

`endif

// File: shared/apts_pkg.sv
// Types shared by the pair trigger sequencer and its conversion engine
// Assumes apts_defines.svh is on the include path
package apts_pkg;

  localparam int NPAIR = 2;

  typedef struct packed {
    logic [7:0] pwm_pri;
    logic [8:0] pwm_sec;
    logic [7:0] pwm_cl;
    logic       pwm_spec;
    logic       pwm_sec_spec;
    logic       tmr1_match;
    logic       tmr2_match;
  } apts_trig_t;

  typedef struct packed {
    logic       irq_en;
    logic       pending;
    logic       soft_trig;
    logic [4:0] trig_sel;
  } apts_pair_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_FIRST  = 3'b010,
    ST_SECOND = 3'b100
  } apts_state_t;

endpackage : apts_pkg

// File: src/apts_conv_engine.sv
// Conversion engine: clock divider and two-channel pair sequence
// Assumes a start is given only while idle
`timescale 1ns/1ns
`include "apts_defines.svh"
module apts_conv_engine
  import apts_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_en,
  input  wire logic       i_start,
  input  wire logic       i_pair,
  input  wire logic       i_odd_first,
  input  wire logic [2:0] i_div,
  output logic            o_busy,
  output logic            o_done,
  output logic            o_done_pair,
  output logic [4:0]      o_chan
);
  apts_state_t st_r, st_nxt;
  logic [2:0]  div_r, div_nxt;
  logic [3:0]  tick_r, tick_nxt;
  logic        pair_r, pair_nxt;
  logic        odd_r, odd_nxt;
  logic        done_r, done_nxt;
  logic        conv_en;

  // Divide by field plus one
  assign conv_en = (div_r == i_div);

  always_comb begin
    st_nxt   = st_r;
    div_nxt  = conv_en ? 3'h0 : div_r + 3'h1;
    tick_nxt = tick_r;
    pair_nxt = pair_r;
    odd_nxt  = odd_r;
    done_nxt = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        div_nxt  = 3'h0;
        tick_nxt = 4'h0;
        if (i_start && i_en) begin
          st_nxt   = ST_FIRST;
          pair_nxt = i_pair;
          odd_nxt  = i_odd_first;
        end
      end
      ST_FIRST: begin
        if (conv_en) begin
          tick_nxt = tick_r + 4'h1;
          if (tick_r == `APTS_CONV_TICKS - 4'h1) begin
            tick_nxt = 4'h0;
            st_nxt   = ST_SECOND;
          end
        end
      end
      ST_SECOND: begin
        if (conv_en) begin
          tick_nxt = tick_r + 4'h1;
          if (tick_r == `APTS_CONV_TICKS - 4'h1) begin
            st_nxt   = ST_IDLE;
            done_nxt = 1'b1;
          end
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    // Turning the converter off abandons the pair; its flags stay
    if (!i_en) begin
      st_nxt   = ST_IDLE;
      done_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r   <= ST_IDLE;
      div_r  <= 3'h0;
      tick_r <= 4'h0;
      pair_r <= 1'b0;
      odd_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
      pair_r <= pair_nxt;
      odd_r  <= odd_nxt;
      done_r <= done_nxt;
    end
  end

  assign o_busy      = (st_r != ST_IDLE);
  assign o_done      = done_r;
  assign o_done_pair = pair_r;
  // Odd input first when order bit set
  assign o_chan = {3'h0, pair_r, (st_r == ST_SECOND) ^ odd_r};

endmodule : apts_conv_engine

// File: src/apts_sequencer.sv
// ADC pair trigger sequencer: registers, trigger select, flags, jump table
// Assumes a one-cycle register port, triggers synchronous to I_CLK_SYS
`timescale 1ns/1ns
`include "apts_defines.svh"
module apts_sequencer
  import apts_pkg::*;
(
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_NRST,
  input  wire logic [3:0]  I_ADDR,
  input  wire logic [15:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  input  wire apts_trig_t  I_TRIG,
  output logic [15:0]      O_RDATA,
  output logic [NPAIR-1:0] O_PAIR_IRQ,
  output logic [23:0]      O_PIN_DIGITAL,
  output logic             O_CONV_BUSY,
  output logic [4:0]       O_CONV_CHAN
);

  // Trigger source decode, shared by every pair
  function automatic logic trig_hit(
    input logic [4:0] sel,
    input apts_trig_t trg,
    input logic       sw,
    input logic       gsw
  );
    logic hit;
    hit = 1'b0;
    if (sel == `APTS_TRG_OFF)
      hit = 1'b0;
    else if (sel == `APTS_TRG_SW)
      hit = sw;
    else if (sel == `APTS_TRG_GSW)
      hit = gsw | sw;
    else if (sel == `APTS_TRG_SPEC)
      hit = trg.pwm_spec;
    else if (sel <= `APTS_TRG_PRI_HI)
      hit = trg.pwm_pri[3'(sel - `APTS_TRG_PRI_LO)];
    else if (sel == `APTS_TRG_TMR1)
      hit = trg.tmr1_match;
    else if (sel == `APTS_TRG_SEC_SPEC)
      hit = trg.pwm_sec_spec;
    else if (sel <= `APTS_TRG_SEC_HI)
      hit = trg.pwm_sec[4'(sel - `APTS_TRG_SEC_LO)];
    else if (sel <= `APTS_TRG_CL_HI)
      hit = trg.pwm_cl[3'(sel - `APTS_TRG_CL_LO)];
    else
      hit = trg.tmr2_match;
    return hit;
  endfunction : trig_hit

  // Lowest numbered set bit wins
  function automatic logic [3:0] prio_enc(
    input logic [NPAIR-1:0] req
  );
    logic [3:0] idx;
    idx = 4'h0;
    for (int k = NPAIR - 1; k >= 0; k--) begin
      if (req[k])
        idx = 4'(k);
    end
    return idx;
  endfunction : prio_enc

  // Register state
  logic [15:0]      ctrl_r, ctrl_nxt;
  logic [15:0]      base_r, base_nxt;
  logic [23:0]      psel_r, psel_nxt;
  apts_pair_t       pair_r   [NPAIR];
  apts_pair_t       pair_nxt [NPAIR];
  logic [NPAIR-1:0] rdy_r, rdy_nxt;
  logic [NPAIR-1:0] irq_r, irq_nxt;
  logic [15:0]      rdata_r, rdata_nxt;
  logic             start_r, start_nxt;
  logic             spair_r, spair_nxt;

  // Engine and decode wires
  logic             conv_on;
  logic             eng_busy;
  logic             eng_done;
  logic             eng_pair;
  logic [4:0]       eng_chan;
  logic [NPAIR-1:0] hit;
  logic [NPAIR-1:0] pend_vec;
  logic [NPAIR-1:0] done_vec;
  logic [3:0]       pend_idx;
  logic             wr_ctrl;
  logic             wr_stat;
  logic             wr_pair;
  logic [15:0]      jump_addr;

  assign conv_on = ctrl_r[`APTS_CTRL_ON];
  assign wr_ctrl = I_WR && (I_ADDR == `APTS_OFF_CTRL);
  assign wr_stat = I_WR && (I_ADDR == `APTS_OFF_STAT);
  assign wr_pair = I_WR && (I_ADDR == `APTS_OFF_PAIRCTL0);

  genvar g;
  generate
    for (g = 0; g < NPAIR; g++) begin : g_pair
      // Off means no trigger is taken
      assign hit[g] = conv_on && trig_hit(pair_r[g].trig_sel, I_TRIG,
                                          pair_r[g].soft_trig,
                                          ctrl_r[`APTS_CTRL_GSW]);
      assign pend_vec[g] = pair_r[g].pending;
      assign done_vec[g] = eng_done && (eng_pair == 1'(g));
    end
  endgenerate

  // Base plus encoded ready pair from bit 2 up; bit 1 follows the base, bit 0 zero
  assign jump_addr = (base_r & `APTS_BASE_MASK)
                   + {10'h000, prio_enc(rdy_r), 2'b00};

  // Control, base and pin select
  always_comb begin
    ctrl_nxt = ctrl_r;
    base_nxt = base_r;
    psel_nxt = psel_r;
    // Configuration writes are not locked; software keeps them off-only
    if (wr_ctrl)
      ctrl_nxt = I_WDATA & `APTS_CTRL_MASK;
    if (I_WR && (I_ADDR == `APTS_OFF_BASE))
      base_nxt = I_WDATA & `APTS_BASE_MASK;
    if (I_WR && (I_ADDR == `APTS_OFF_PSEL_LO))
      psel_nxt[15:0] = I_WDATA & `APTS_PSEL_LO_MASK;
    if (I_WR && (I_ADDR == `APTS_OFF_PSEL_HI))
      psel_nxt[23:16] = I_WDATA[7:0];
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl_r <= `APTS_CTRL_RST;
      base_r <= 16'h0000;
      psel_r <= 24'h000000;
    end else begin
      ctrl_r <= ctrl_nxt;
      base_r <= base_nxt;
      psel_r <= psel_nxt;
    end
  end

  // Pair flags: pending, soft trigger, ready, interrupt
  always_comb begin
    rdy_nxt = rdy_r;
    irq_nxt = '0;
    for (int p = 0; p < NPAIR; p++) begin
      pair_nxt[p] = pair_r[p];
      // Software write: enable, soft trigger, source; pending is hardware's
      if (wr_pair) begin
        pair_nxt[p].irq_en    = I_WDATA[8*p+7];
        pair_nxt[p].soft_trig = I_WDATA[8*p+5];
        pair_nxt[p].trig_sel  = I_WDATA[8*p+:5];
      end
      // Ready clears on written zero, set wins over it
      if (wr_stat && !I_WDATA[p])
        rdy_nxt[p] = 1'b0;
      if (done_vec[p]) begin
        pair_nxt[p].pending = 1'b0;
        rdy_nxt[p]          = 1'b1;
        irq_nxt[p]          = pair_r[p].irq_en;
      end
      // A fresh trigger while pending is merged; set wins over done
      if (hit[p]) begin
        pair_nxt[p].pending = 1'b1;
        if (!pair_r[p].pending)
          pair_nxt[p].soft_trig = 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      for (int p = 0; p < NPAIR; p++)
        pair_r[p] <= `APTS_PAIR_RST;
      rdy_r <= '0;
      irq_r <= '0;
    end else begin
      for (int p = 0; p < NPAIR; p++)
        pair_r[p] <= pair_nxt[p];
      rdy_r <= rdy_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Dispatch: one start at a time, lowest pending pair first
  assign pend_idx = prio_enc(pend_vec);

  always_comb begin
    start_nxt = 1'b0;
    spair_nxt = spair_r;
    // Waits for a free engine, so held requests are kept
    if (conv_on && !eng_busy && !start_r && !eng_done && (pend_vec != '0)) begin
      start_nxt = 1'b1;
      spair_nxt = pend_idx[0];
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      start_r <= 1'b0;
      spair_r <= 1'b0;
    end else begin
      start_r <= start_nxt;
      spair_r <= spair_nxt;
    end
  end

  apts_conv_engine u_engine (
    .i_clk       (I_CLK_SYS),
    .i_nrst      (I_NRST),
    .i_en        (conv_on),
    .i_start     (start_r),
    .i_pair      (spair_r),
    .i_odd_first (ctrl_r[`APTS_CTRL_ORDER]),
    .i_div       (ctrl_r[`APTS_CTRL_DIV_HI:0]),
    .o_busy      (eng_busy),
    .o_done      (eng_done),
    .o_done_pair (eng_pair),
    .o_chan      (eng_chan)
  );

  // Read port: data stand one cycle after the strobe, else zero
  always_comb begin
    rdata_nxt = 16'h0000;
    if (I_RD) begin
      unique case (I_ADDR)
        `APTS_OFF_CTRL:     rdata_nxt = ctrl_r;
        `APTS_OFF_STAT:     rdata_nxt = {14'h0000, rdy_r};
        `APTS_OFF_BASE:     rdata_nxt = jump_addr;
        `APTS_OFF_PSEL_LO:  rdata_nxt = psel_r[15:0];
        `APTS_OFF_PSEL_HI:  rdata_nxt = {8'h00, psel_r[23:16]};
        `APTS_OFF_PAIRCTL0: rdata_nxt = {pair_r[1], pair_r[0]};
        default:            rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Outputs registered; engine state is one cycle late on the pins
  logic       busy_q;
  logic [4:0] chan_q;

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      rdata_r <= 16'h0000;
      busy_q  <= 1'b0;
      chan_q  <= 5'h00;
    end else begin
      rdata_r <= rdata_nxt;
      busy_q  <= eng_busy;
      chan_q  <= eng_chan;
    end
  end

  assign O_RDATA       = rdata_r;
  assign O_PAIR_IRQ    = irq_r;
  // One selects digital pin, mux input tied low
  assign O_PIN_DIGITAL = psel_r;
  assign O_CONV_BUSY   = busy_q;
  assign O_CONV_CHAN   = chan_q;

endmodule : apts_sequencer

// File: tb/apts_monitor.sv
// Port checker for the pair trigger sequencer
// Assumes a bind from the bench top, one clock domain
`timescale 1ns/1ns
module apts_monitor
  import apts_pkg::*;
(
  input  wire logic             I_CLK_SYS,
  input  wire logic             I_NRST,
  input  wire logic [3:0]       I_ADDR,
  input  wire logic [15:0]      I_WDATA,
  input  wire logic             I_WR,
  input  wire logic             I_RD,
  input  wire apts_trig_t       I_TRIG,
  input  wire logic [15:0]      O_RDATA,
  input  wire logic [NPAIR-1:0] O_PAIR_IRQ,
  input  wire logic [23:0]      O_PIN_DIGITAL,
  input  wire logic             O_CONV_BUSY,
  input  wire logic [4:0]       O_CONV_CHAN
);
  logic       on_r;
  logic       ord_r;
  logic [1:0] base_lo_r;
  // Shadow of on and order bits, and of the stored base low bits
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      on_r      <= 1'b0;
      ord_r     <= 1'b0;
      base_lo_r <= 2'b00;
    end else begin
      if (I_WR && I_ADDR == 4'h0) begin
        on_r  <= I_WDATA[15];
        ord_r <= I_WDATA[6];
      end
      if (I_WR && I_ADDR == 4'h2)
        base_lo_r <= {I_WDATA[1], 1'b0};
    end
  end
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  a_rdata_idle: assert property (!I_RD |=> O_RDATA == 16'h0) else $error("read data not idle");
  // Encoded pair adds nothing below bit 2, so low bits follow the stored base
  a_base_align: assert property (I_RD && I_ADDR == 4'h2 |=> O_RDATA[1:0] == base_lo_r)
    else $error("jump address low bits wrong");
  a_ctrl_mask: assert property (I_RD && I_ADDR == 4'h0 |=> (O_RDATA & ~16'hb5f7) == 16'h0)
    else $error("control spare bits set");
  a_pin_low: assert property (I_WR && I_ADDR == 4'h3 |=> O_PIN_DIGITAL[15:0] == $past(I_WDATA))
    else $error("pin select not updated");
  a_irq_single: assert property (O_PAIR_IRQ != 2'b00 |=> O_PAIR_IRQ == 2'b00)
    else $error("irq longer than one cycle");
  a_irq_onehot: assert property ($onehot0(O_PAIR_IRQ)) else $error("two pair irqs at once");
  a_first_chan: assert property ($rose(O_CONV_BUSY) |-> O_CONV_CHAN[0] == ord_r)
    else $error("wrong first input of pair");
  a_off_quiet: assert property (!on_r && !O_CONV_BUSY |=> !O_CONV_BUSY)
    else $error("conversion started while off");
  a_conv_hold: assert property ($rose(O_CONV_BUSY) |-> O_CONV_BUSY [*8])
    else $error("conversion too short");
endmodule : apts_monitor

// File: tb/apts_sequencer_tb.sv
// Self-checking bench for the pair trigger sequencer
// Assumes the trigger source model and the port checker
`timescale 1ns/1ns
module apts_sequencer_tb;
  import apts_pkg::*;
  typedef struct {logic [4:0] code; logic en; logic done;} apts_row_t;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, fire_r = 1'b0, oth_r = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0, rdata;
  logic [4:0] code_r = 5'h0, chan, ch;
  logic [1:0] irq;
  logic [23:0] pins;
  logic busy, seen;
  apts_trig_t trig;
  apts_row_t rows[32];
  int bad_count = 0, cmp_count = 0, n0, n7;
  apts_sequencer u_apts_sequencer (.I_CLK_SYS(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .I_TRIG(trig), .O_RDATA(rdata), .O_PAIR_IRQ(irq), .O_PIN_DIGITAL(pins),
    .O_CONV_BUSY(busy), .O_CONV_CHAN(chan));
  apts_trig_src u_apts_trig_src (.i_clk(clk), .i_code(code_r), .i_fire(fire_r), .i_others(oth_r), .o_trig(trig));
  initial begin
    forever #5 clk = ~clk;
  end
  task chk(input string n, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task rreg(input logic [3:0] a, input logic [15:0] e, input string n);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, 24'(e), 24'(rdata));
  endtask : rreg
  task fire(input logic [4:0] c, input logic oth);
    if (!oth && c == 5'h01) wreg(4'h5, {8'h0, 3'b001, c} | 16'h0080 & {8'h0, rows[c].en, 7'h0});
    else if (!oth && c == 5'h02) begin
      wreg(4'h0, 16'h8400);
      rreg(4'h0, 16'h8400, "global bit");
      wreg(4'h0, 16'h8000);
    end else begin
      @(posedge clk);
      fire_r <= 1'b1; oth_r <= oth; code_r <= c;
      @(posedge clk);
      fire_r <= 1'b0;
    end
  endtask : fire
  task wait_irq(input int p);
    seen = 1'b0;
    repeat (300) begin
      @(posedge clk);
      #1 if (irq[p] === 1'b1) begin seen = 1'b1; break; end
    end
  endtask : wait_irq
  task busy_len(output int n);
    n = 0;
    repeat (300) begin @(posedge clk); #1 if (busy === 1'b1) break; end
    ch = chan;
    while (busy === 1'b1 && n < 2000) begin n++; @(posedge clk); #1; end
  endtask : busy_len
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    #400000 bad_count++;
    report_and_stop();
  end
  initial begin
    for (int i = 0; i < 32; i++) rows[i] = '{5'(i), i[0], i != 0};
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rreg(4'h0, 16'h0003, "control reset");
    for (int a = 1; a < 6; a++) rreg(4'(a), 16'h0, "reset value");
    wreg(4'h0, 16'hffff);
    rreg(4'h0, 16'hb5f7, "control mask");
    wreg(4'h0, 16'h7fff);
    wreg(4'h0, 16'h0000);
    wreg(4'h2, 16'hffff);
    rreg(4'h2, 16'hfffe, "base mask");
    wreg(4'h3, 16'ha5c3);
    wreg(4'h4, 16'hffff);
    rreg(4'h4, 16'h00ff, "pin high mask");
    chk("pins", 24'hffa5c3, pins);
    rreg(4'h9, 16'h0, "unmapped");
    wreg(4'h2, 16'h1230);
    wreg(4'h5, 16'h00a1);
    repeat (30) @(posedge clk);
    rreg(4'h5, 16'h00a1, "off no trigger");
    wreg(4'h5, 16'h0000);
    wreg(4'h0, 16'h8000);
    foreach (rows[i]) begin
      wreg(4'h5, {8'h0, rows[i].en, 2'b00, rows[i].code});
      fire(rows[i].code, 1'b1);
      repeat (4) @(posedge clk);
      rreg(4'h5, {8'h0, rows[i].en, 2'b00, rows[i].code}, "no pending");
      fire(rows[i].code, 1'b0);
      wait_irq(0);
      chk("irq", 24'(rows[i].done & rows[i].en), 24'(seen));
      rreg(4'h1, {15'h0, rows[i].done}, "ready");
      rreg(4'h2, 16'h1230, "jump");
      wreg(4'h1, 16'hfffe);
    end
    wreg(4'h5, 16'h0202);
    wreg(4'h5, 16'ha2a2);
    rreg(4'h5, 16'hc2c2, "both pending");
    busy_len(n0);
    chk("first pair", 24'h0, 24'(ch[4:1]));
    wait_irq(1);
    chk("held pair irq", 24'h1, 24'(seen));
    rreg(4'h1, 16'h0003, "both ready");
    rreg(4'h2, 16'h1230, "jump pair0");
    wreg(4'h1, 16'h0002);
    rreg(4'h1, 16'h0002, "ready1 only");
    rreg(4'h2, 16'h1234, "jump pair1");
    wreg(4'h1, 16'h0000);
    wreg(4'h5, 16'h0002);
    wreg(4'h0, 16'h0000);
    wreg(4'h0, 16'h0047);
    wreg(4'h0, 16'h8047);
    wreg(4'h5, 16'h0022);
    busy_len(n7);
    chk("odd first", 24'h1, 24'(ch));
    wreg(4'h0, 16'h0000);
    wreg(4'h0, 16'h8000);
    wreg(4'h5, 16'h0022);
    busy_len(n0);
    chk("even first", 24'h0, 24'(ch));
    chk("divider span", 24'(168), 24'(n7 - n0));
    // Reset in mid conversion, ready and pair state must not survive
    wreg(4'h5, 16'h0022);
    repeat (6) @(posedge clk);
    nrst <= 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rreg(4'h0, 16'h0003, "control after reset");
    rreg(4'h5, 16'h0000, "pair after reset");
    rreg(4'h1, 16'h0000, "ready after reset");
    report_and_stop();
  end
endmodule : apts_sequencer_tb
bind apts_sequencer apts_monitor u_apts_monitor (.I_CLK_SYS, .I_NRST, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
  .I_TRIG, .O_RDATA, .O_PAIR_IRQ, .O_PIN_DIGITAL, .O_CONV_BUSY, .O_CONV_CHAN);

// File: tb/apts_trig_src.sv
// Trigger sources: PWM generators and timers, one pulse per request
// Assumes requests arrive just after a rising edge
`timescale 1ns/1ns
module apts_trig_src
  import apts_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [4:0] i_code,
  input  wire logic       i_fire,
  input  wire logic       i_others,
  output apts_trig_t      o_trig
);
  apts_trig_t one;
  always_comb begin
    one = '0;
    if (i_code == 5'h03) one.pwm_spec = 1'b1;
    else if (i_code <= 5'h0b && i_code >= 5'h04) one.pwm_pri[3'(i_code - 5'h04)] = 1'b1;
    else if (i_code == 5'h0c) one.tmr1_match = 1'b1;
    else if (i_code == 5'h0d) one.pwm_sec_spec = 1'b1;
    else if (i_code <= 5'h16 && i_code >= 5'h0e) one.pwm_sec[4'(i_code - 5'h0e)] = 1'b1;
    else if (i_code <= 5'h1e && i_code >= 5'h17) one.pwm_cl[3'(i_code - 5'h17)] = 1'b1;
    else if (i_code == 5'h1f) one.tmr2_match = 1'b1;
  end
  // Others mode pulses every source but the chosen one
  always_ff @(posedge i_clk) begin
    o_trig <= i_fire ? (i_others ? ~one : one) : '0;
  end
endmodule : apts_trig_src
